// ---- logic/sfq_core.sv ----
/*
 Serial flash instruction sequencer: quad output, dual I/O and quad I/O reads
 with continuous mode and wrap, and page program with busy timing.
 Assumes serial clock well below a quarter of clk, a memory read port on clk,
 and a protection decoder on clk answering for the page on pgm_check_page.
*/
`timescale 1ns/10ps
module sfq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clr,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} sfq_fifo_t;
	sfq_fifo_t        cur;
	sfq_fifo_t        next_cur;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready  = (cur.cnt != (AW+1)'(DEPTH));
	assign out_valid = (cur.cnt != '0);
	assign out_data  = mem[cur.rp];
	assign push      = in_valid & in_ready & ~clr;
	assign pop       = out_valid & out_ready & ~clr;

	always_comb begin
		next_cur = cur;
		if (clr) begin
			next_cur = '0;
		end else begin
			if (push) next_cur.wp = bump(cur.wp);
			if (pop) next_cur.rp = bump(cur.rp);
			next_cur.cnt = (AW+1)'(cur.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cur <= '0;
		else cur <= next_cur;
	end

	always_ff @(posedge clk) begin
		if (push) mem[cur.wp] <= in_data;
	end
endmodule

module sfq_core
	import sfq_pkg::*;
#(
	parameter int PROGRAM_CYCLE_TIME = PROGRAM_CYCLE_TIME_NS
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe,
	input  wire logic        quad_enable_bit,
	input  wire logic        four_wire_command_mode,
	input  wire logic        read_param_six,
	input  wire logic        wrap_enable,
	input  wire logic [1:0]  wrap_len,
	input  wire logic        write_enable_set,
	input  wire logic        page_protected,
	output logic             write_enable_latch,
	output logic             busy,
	output logic      [15:0] pgm_check_page,
	output logic             mem_rd_req,
	output logic      [23:0] mem_rd_addr,
	input  wire logic        mem_rd_valid,
	input  wire logic [7:0]  mem_rd_data,
	output logic             pgm_we,
	output logic      [23:0] pgm_addr,
	output logic      [7:0]  pgm_data
);
	localparam int PGM_CYC = (PROGRAM_CYCLE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TW      = $clog2(PGM_CYC + 1);

	typedef struct packed {
		logic            cs_s1, cs_s2, ck_s1, ck_s2, ck_d;
		logic [3:0]      io_s1, io_s2;
		sfq_state_t      st;
		sfq_cmd_t        cmd;
		logic [2:0]      bpc;
		logic [4:0]      cnt;
		logic [3:0]      dtgt;
		logic [23:0]     sh;
		logic            cont_dio, cont_qio;
		logic [7:0]      obyte;
		logic [3:0]      obits;
		logic [3:0]      io_out, io_oe;
		logic [23:0]     fetch_addr, rd_addr;
		logic            rd_req, pend, stale, fclr;
		logic [255:0]    pmask;
		logic [7:0]      pidx;
		logic [15:0]     page;
		logic            whole, busy, wen_latch;
		logic [8:0]      scan;
		logic [TW-1:0]   timer;
		logic            pgm_we;
		logic [23:0]     pgm_addr;
	} sfq_core_t;

	sfq_core_t   cur;
	sfq_core_t   next_cur;
	logic [7:0]  pbuf [PAGE_BYTES];
	logic        pb_we;
	logic [7:0]  pb_wd;
	logic        rise;
	logic        fall;
	logic [23:0] shifted;
	logic        op_fin;
	logic        addr_fin;
	logic        mode_fin;
	logic        wrap_act;
	logic [5:0]  wmask;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [7:0]  fifo_dout;
	logic        fifo_pop;
	logic [7:0]  byt;

	function automatic logic [23:0] shin(input logic [23:0] v, input logic [2:0] w,
		input logic [3:0] d);
		case (w)
			LANES_4: return {v[19:0], d};
			LANES_2: return {v[21:0], d[1:0]};
			default: return {v[22:0], d[0]};
		endcase
	endfunction

	assign rise     = cur.ck_s2 & ~cur.ck_d;
	assign fall     = ~cur.ck_s2 & cur.ck_d;
	assign shifted  = shin(cur.sh, cur.bpc, cur.io_s2);
	assign op_fin   = rise & ~cur.cs_s2 & (cur.st == ST_OPC) & (5'(cur.cnt + cur.bpc) == OP_BITS);
	assign addr_fin = rise & ~cur.cs_s2 & (cur.st == ST_ADDR)
		& (5'(cur.cnt + cur.bpc) == ADDR_BITS);
	assign mode_fin = rise & ~cur.cs_s2 & (cur.st == ST_MODE)
		& (5'(cur.cnt + cur.bpc) == MODE_BITS);
	// Wrap only for quad I/O in single-wire command mode
	assign wrap_act = (cur.cmd == CM_QIO) & ~four_wire_command_mode & wrap_enable;
	assign wmask    = 6'(({2'b00, 4'h8} << wrap_len) - 6'h01);

	sfq_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clr       (cur.fclr),
		.in_valid  (mem_rd_valid & cur.pend),
		.in_ready  (fifo_ready),
		.in_data   (mem_rd_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_dout)
	);

	always_comb begin
		next_cur = cur;
		pb_we = 1'b0;
		pb_wd = shifted[7:0];
		fifo_pop = 1'b0;
		byt = cur.obyte;
		next_cur.cs_s1 = cs_n;
		next_cur.cs_s2 = cur.cs_s1;
		next_cur.ck_s1 = sclk;
		next_cur.ck_s2 = cur.ck_s1;
		next_cur.ck_d = cur.ck_s2;
		next_cur.io_s1 = io_in;
		next_cur.io_s2 = cur.io_s1;
		next_cur.rd_req = 1'b0;
		next_cur.fclr = 1'b0;
		next_cur.pgm_we = 1'b0;
		if (write_enable_set) next_cur.wen_latch = 1'b1;
		if (mem_rd_valid) begin
			next_cur.pend = 1'b0;
			next_cur.stale = 1'b0;
		end
		if (cur.cs_s2) begin
			// Commit only on a whole final byte with the latch set and page open
			if (cur.st == ST_PDATA && cur.whole && cur.wen_latch && !page_protected
				&& !cur.busy) begin
				next_cur.busy = 1'b1;
				next_cur.wen_latch = 1'b0;
				next_cur.scan = '0;
				next_cur.timer = '0;
			end
			next_cur.st = ST_IDLE;
			next_cur.io_oe = '0;
		end else if (cur.st == ST_IDLE) begin
			next_cur.cnt = '0;
			next_cur.sh = '0;
			next_cur.obits = '0;
			if (cur.busy) begin
				next_cur.st = ST_SKIP;
			end else if (cur.cont_dio) begin
				next_cur.st = ST_ADDR;
				next_cur.cmd = CM_DIO;
				next_cur.bpc = LANES_2;
			end else if (cur.cont_qio && quad_enable_bit) begin
				next_cur.st = ST_ADDR;
				next_cur.cmd = CM_QIO;
				next_cur.bpc = LANES_4;
			end else begin
				next_cur.st = ST_OPC;
				next_cur.bpc = four_wire_command_mode ? LANES_4 : LANES_1;
			end
		end else if (rise) begin
			next_cur.sh = shifted;
			next_cur.cnt = 5'(cur.cnt + cur.bpc);
			case (cur.st)
				ST_OPC: begin
					if (op_fin) begin
						next_cur.cnt = '0;
						next_cur.st = ST_SKIP;
						if (shifted[7:0] == OP_QUAD_OUT && quad_enable_bit
							&& !four_wire_command_mode) begin
							next_cur.st = ST_ADDR;
							next_cur.cmd = CM_QOUT;
							next_cur.bpc = LANES_1;
						end else if (shifted[7:0] == OP_DUAL_IO && !four_wire_command_mode) begin
							next_cur.st = ST_ADDR;
							next_cur.cmd = CM_DIO;
							next_cur.bpc = LANES_2;
						end else if (shifted[7:0] == OP_QUAD_IO && quad_enable_bit) begin
							next_cur.st = ST_ADDR;
							next_cur.cmd = CM_QIO;
							next_cur.bpc = LANES_4;
						end else if (shifted[7:0] == OP_PAGE_PGM && cur.wen_latch) begin
							next_cur.st = ST_ADDR;
							next_cur.cmd = CM_PGM;
						end else if (shifted[7:0] == OP_MODE_RST) begin
							next_cur.cont_dio = 1'b0;
							next_cur.cont_qio = 1'b0;
						end
					end
				end
				ST_ADDR: begin
					if (addr_fin) begin
						next_cur.cnt = '0;
						next_cur.fetch_addr = shifted;
						next_cur.fclr = 1'b1;
						next_cur.pend = 1'b0;
						next_cur.stale = (cur.stale | cur.pend) & ~mem_rd_valid;
						if (cur.cmd == CM_QOUT) begin
							next_cur.st = ST_DUMMY;
							next_cur.dtgt = QOUT_DUMMY;
							next_cur.bpc = LANES_4;
						end else if (cur.cmd == CM_PGM) begin
							next_cur.st = ST_PDATA;
							next_cur.page = shifted[23:8];
							next_cur.pidx = shifted[7:0];
							next_cur.pmask = '0;
							next_cur.whole = 1'b0;
						end else begin
							next_cur.st = ST_MODE;
						end
					end
				end
				ST_MODE: begin
					if (mode_fin) begin
						next_cur.cnt = '0;
						// Only the upper nibble matters; the lower one is ignored
						if (cur.cmd == CM_DIO) begin
							next_cur.cont_dio = (shifted[7:4] == CONT_NIBBLE);
							// One mode byte: the other read kind loses its skip
							next_cur.cont_qio = 1'b0;
							next_cur.st = ST_RDATA;
						end else begin
							next_cur.cont_qio = (shifted[7:4] == CONT_NIBBLE);
							next_cur.cont_dio = 1'b0;
							if (four_wire_command_mode) begin
								next_cur.dtgt = 4'((read_param_six ? FW_DUMMY_6 : FW_DUMMY_4)
									- FW_MODE_SHARE);
							end else begin
								next_cur.dtgt = QIO_DUMMY;
							end
							next_cur.st = (next_cur.dtgt == 4'h0) ? ST_RDATA : ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (5'(cur.cnt + 5'h01) == {1'b0, cur.dtgt}) next_cur.st = ST_RDATA;
					else next_cur.cnt = 5'(cur.cnt + 5'h01);
				end
				ST_PDATA: begin
					if (5'(cur.cnt + cur.bpc) == OP_BITS) begin
						pb_we = 1'b1;
						next_cur.pmask[cur.pidx] = 1'b1;
						next_cur.pidx = 8'(cur.pidx + 8'h01);
						next_cur.whole = 1'b1;
						next_cur.cnt = '0;
					end else begin
						next_cur.whole = 1'b0;
					end
				end
				default: next_cur.cnt = cur.cnt;
			endcase
		end else if (fall && cur.st == ST_RDATA) begin
			// Empty fifo here means the memory fell behind; the old entry at the read pointer goes out
			if (cur.obits == 4'h0) begin
				byt = fifo_dout;
				fifo_pop = fifo_valid;
			end
			if (cur.bpc == LANES_4) begin
				next_cur.io_out = byt[7:4];
				next_cur.obyte = {byt[3:0], 4'h0};
				next_cur.io_oe = 4'hf;
			end else begin
				next_cur.io_out = {2'b00, byt[7:6]};
				next_cur.obyte = {byt[5:0], 2'b00};
				next_cur.io_oe = 4'h3;
			end
			next_cur.obits = 4'(((cur.obits == 4'h0) ? 4'h8 : cur.obits) - {1'b0, cur.bpc});
		end
		// One read in flight keeps the fifo from being overrun
		if ((cur.st == ST_MODE || cur.st == ST_DUMMY || cur.st == ST_RDATA) && !cur.cs_s2
			&& !cur.pend && !cur.stale && !cur.fclr && fifo_ready) begin
			next_cur.rd_req = 1'b1;
			next_cur.rd_addr = cur.fetch_addr;
			next_cur.pend = 1'b1;
			if (wrap_act) begin
				next_cur.fetch_addr = {cur.fetch_addr[23:6],
					(cur.fetch_addr[5:0] & ~wmask) | (6'(cur.fetch_addr[5:0] + 6'h01) & wmask)};
			end else begin
				next_cur.fetch_addr = 24'(cur.fetch_addr + 24'h00_0001);
			end
		end
		if (cur.busy) begin
			if (!cur.scan[8]) begin
				next_cur.pgm_we = cur.pmask[cur.scan[7:0]];
				next_cur.pgm_addr = {cur.page, cur.scan[7:0]};
				next_cur.scan = 9'(cur.scan + 9'h001);
			end
			next_cur.timer = TW'(cur.timer + 1'b1);
			if (cur.timer == TW'(PGM_CYC - 1)) next_cur.busy = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.cs_s1 <= 1'b1;
			cur.cs_s2 <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	always_ff @(posedge clk) begin
		if (pb_we) pbuf[cur.pidx] <= pb_wd;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pgm_data <= '0;
		else pgm_data <= pbuf[cur.scan[7:0]];
	end

	assign io_out             = cur.io_out;
	assign io_oe              = cur.io_oe;
	assign write_enable_latch = cur.wen_latch;
	assign busy               = cur.busy;
	assign pgm_check_page     = cur.page;
	assign mem_rd_req         = cur.rd_req;
	assign mem_rd_addr        = cur.rd_addr;
	assign pgm_we             = cur.pgm_we;
	assign pgm_addr           = cur.pgm_addr;

	int bcnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) bcnt <= 0;
		else if (!cur.busy) bcnt <= 0;
		else bcnt <= bcnt + 1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_qout_needs_qe: assert property (
		op_fin && shifted[7:0] == OP_QUAD_OUT && !quad_enable_bit |=> cur.st == ST_SKIP)
		else $error("quad output read taken without quad enable");
	chk_qout_dummy_len: assert property (
		$rose(cur.st == ST_RDATA) && cur.cmd == CM_QOUT |-> $past(cur.cnt) == 5'h07)
		else $error("quad output read dummy count wrong");
	chk_pgm_needs_wel: assert property (
		$rose(cur.busy) |-> $past(cur.wen_latch) && $past(cur.st) == ST_PDATA)
		else $error("program started without write enable");
	chk_wel_clear_busy: assert property (
		$rose(cur.busy) |-> !write_enable_latch)
		else $error("write enable latch not cleared at busy");
	chk_busy_length: assert property (
		$fell(cur.busy) |-> bcnt == PGM_CYC)
		else $error("program cycle length wrong");
	chk_cont_dual: assert property (
		cur.st == ST_IDLE && !cur.cs_s2 && cur.cont_dio && !cur.busy
		|=> cur.st == ST_ADDR && cur.cmd == CM_DIO)
		else $error("continuous dual read did not skip opcode");
	chk_mode_other: assert property (
		mode_fin && shifted[7:4] != CONT_NIBBLE |=> !cur.cont_dio && !cur.cont_qio)
		else $error("continuous mode kept for non A nibble");
	chk_page_wrap: assert property (
		pb_we && cur.pidx == 8'hff |=> cur.pidx == 8'h00)
		else $error("page address did not wrap");
	chk_partial_drop: assert property (
		cur.cs_s2 && cur.st == ST_PDATA && !cur.whole && !cur.busy |=> !cur.busy)
		else $error("partial byte program was executed");
	chk_oe_data_only: assert property (
		cur.io_oe != 4'h0 |-> cur.st == ST_RDATA || $past(cur.st) == ST_RDATA)
		else $error("pins driven outside data phase");

	cov_cont_quad: cover property (cur.st == ST_IDLE && !cur.cs_s2 && cur.cont_qio ##1
		cur.st == ST_ADDR);
	cov_pgm_commit: cover property ($rose(cur.busy));
	cov_wrap_read: cover property (cur.rd_req && wrap_act);
	cov_page_roll: cover property (pb_we && cur.pidx == 8'hff);
endmodule

// ---- pkg/sfq_pkg.sv ----
/*
 Constants and types for the serial flash read and page program sequencer.
 Assumes one 25 MHz system clock; all serial pins are resampled on it.
*/
// Notes on behaviour
// - Quad output read needs quad enable set
// - Quad output read waits eight dummy clocks
// - Dual I/O read moves two bits per clock
// - Mode byte upper nibble selects opcode omission
// - Dual mode nibble A skips next opcode
// - Other mode nibbles require full opcode next
// - Mode reset returns to opcode first decoding
// - Quad I/O read needs quad enable, four lanes
// - Quad mode nibble A skips next opcode
// - Burst wrap setting steers quad I/O reads
// - Wrap stays inside aligned section until deselect
// - Four wire dummy count four or six
// - Four wire continuous read; mode counts dummy
// - No wrap for quad I/O in four wire
// - Page program needs latch, address, data byte
// - Program address wraps inside the page
// - Partial final byte discards the program
// - Busy for program cycle time, then clear
// - Write enable latch clears when busy starts
// - Protected page is never programmed
// - Capture on rising, drive on falling edge
package sfq_pkg;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO  = 8'heb;
	localparam logic [7:0] OP_PAGE_PGM = 8'h02;
	localparam logic [7:0] OP_MODE_RST = 8'hff;
	localparam logic [3:0] CONT_NIBBLE = 4'ha;
	localparam logic [4:0] OP_BITS     = 5'h08;
	localparam logic [4:0] ADDR_BITS   = 5'h18;
	localparam logic [4:0] MODE_BITS   = 5'h08;
	localparam logic [3:0] QOUT_DUMMY  = 4'h8;
	localparam logic [3:0] QIO_DUMMY   = 4'h4;
	localparam logic [3:0] FW_DUMMY_4  = 4'h4;
	localparam logic [3:0] FW_DUMMY_6  = 4'h6;
	localparam logic [3:0] FW_MODE_SHARE = 4'h4;
	localparam logic [2:0] LANES_1     = 3'h1;
	localparam logic [2:0] LANES_2     = 3'h2;
	localparam logic [2:0] LANES_4     = 3'h4;
	localparam int CLK_PERIOD_NS        = 40;
	localparam int PROGRAM_CYCLE_TIME_NS = 700000;
	localparam int PAGE_BYTES          = 256;
	localparam int FIFO_DEPTH          = 8;
	typedef enum logic [2:0] {
		ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_RDATA, ST_PDATA, ST_SKIP
	} sfq_state_t;
	typedef enum logic [2:0] {CM_NONE, CM_QOUT, CM_DIO, CM_QIO, CM_PGM} sfq_cmd_t;
endpackage

// ---- tb/sfq_host_model.sv ----
/*
 Host flash controller model: frames instructions with cs_n, sclk and the IO lanes.
 Assumes the bench merges io_drv with the device drive into io_wire.
*/
`timescale 1ns/10ps
module sfq_host_model (
	input  wire logic       clk,
	input  wire logic [3:0] io_wire,
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] io_drv
);
	logic [3:0] drv;
	logic [3:0] drv_oe;
	logic       tog;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
		drv_oe = 4'h0;
		tog = 1'b0;
	end
	always @(posedge clk) begin
		tog <= ~tog;
	end
	// Released lanes toggle so a stale level never reads as data
	assign io_drv = (drv & drv_oe) | ({4{tog}} ^ 4'h5) & ~drv_oe;
	function automatic logic [3:0] lm(input int lanes);
		return 4'((1 << lanes) - 1);
	endfunction
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Select stays low from before the first clock to after the last clock, partial bits included
	task automatic begin_frame();
		wait_clk(1);
		cs_n <= 1'b0;
		drv_oe <= 4'h0;
		wait_clk(4);
	endtask
	task automatic end_frame();
		sclk <= 1'b0;
		drv_oe <= 4'h0;
		wait_clk(4);
		cs_n <= 1'b1;
		wait_clk(6);
	endtask
	task automatic shift(input logic [31:0] v, input int nbits, input int lanes,
		input logic [3:0] oe);
		int i;
		for (i = nbits / lanes - 1; i >= 0; i--) begin
			sclk <= 1'b0;
			drv <= 4'(v >> (i * lanes)) & lm(lanes);
			drv_oe <= oe;
			wait_clk(4);
			sclk <= 1'b1;
			wait_clk(4);
		end
	endtask
	task automatic recv(input int nclk, input int lanes, output logic [31:0] acc);
		int i;
		acc = '0;
		for (i = 0; i < nclk; i++) begin
			sclk <= 1'b0;
			drv_oe <= 4'h0;
			wait_clk(4);
			acc = (acc << lanes) | 32'(io_wire & lm(lanes));
			sclk <= 1'b1;
			wait_clk(4);
		end
	endtask
endmodule

// ---- tb/sfq_core_tb.sv ----
/*
 Self-checking bench for sfq_core: reads in all lane modes, continuous mode,
 wrap, four-wire mode and page program. Memory answers one cycle after a request.
*/
`timescale 1ns/10ps
module sfq_core_tb;
	import sfq_pkg::*;
	localparam int PGM_NS = 20000;
	logic        clk, rst_n, cs_n, sclk;
	logic [3:0]  io_in, io_out, io_oe, io_drv;
	logic        quad_en, four_wire, rp6, wrap_en, latch_set, page_protected;
	logic        busy_q;
	int          busy_run, busy_len;
	logic [1:0]  wrap_len;
	logic        write_enable_latch, busy, mem_rd_req, mem_rd_valid, pgm_we;
	logic [15:0] pgm_check_page;
	logic [23:0] mem_rd_addr, pgm_addr;
	logic [7:0]  mem_rd_data, pgm_data;
	logic        oe_seen;
	logic [31:0] pq[$];
	int          n_fail, check_count;
	sfq_core #(.PROGRAM_CYCLE_TIME(PGM_NS)) dut_u (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_en),
		.four_wire_command_mode(four_wire), .read_param_six(rp6), .wrap_enable(wrap_en),
		.wrap_len(wrap_len), .write_enable_set(latch_set), .page_protected(page_protected),
		.write_enable_latch(write_enable_latch), .busy(busy),
		.pgm_check_page(pgm_check_page), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .pgm_we(pgm_we), .pgm_addr(pgm_addr),
		.pgm_data(pgm_data));
	sfq_host_model host_u (.clk(clk), .io_wire(io_in), .cs_n(cs_n), .sclk(sclk),
		.io_drv(io_drv));
	assign io_in = (io_oe & io_out) | (~io_oe & io_drv);
	always #20 clk = ~clk;
	always @(posedge clk) begin
		mem_rd_valid <= mem_rd_req;
		mem_rd_data <= mem_rd_addr[7:0] ^ 8'h3c;
		if (io_oe !== 4'h0) oe_seen <= 1'b1;
		if (pgm_we === 1'b1) pq.push_back({pgm_addr, pgm_data});
		// Busy length measured from its own edges, not from the task's timing
		busy_q <= busy;
		if (busy === 1'b1) busy_run <= busy_run + 1;
		else busy_run <= 0;
		if (busy_q === 1'b1 && busy !== 1'b1) busy_len <= busy_run;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] ex(input logic [23:0] a, input logic [23:0] m);
		logic [31:0] r;
		logic [23:0] x;
		int          i;
		r = '0;
		for (i = 0; i < 4; i++) begin
			x = (a & ~m) | ((a + 24'(i)) & m);
			r = (r << 8) | 32'(x[7:0] ^ 8'h3c);
		end
		return r;
	endfunction
	// ol: opcode lanes, 0 skips the opcode; ab: address plus mode bits
	task automatic rd(input logic [7:0] op, input int ol, input logic [31:0] am, input int ab,
		input int al, input int dum, input int dl, output logic [31:0] got);
		host_u.begin_frame();
		if (ol != 0) host_u.shift(32'(op), 8, ol, host_u.lm(ol));
		host_u.shift(am, ab, al, host_u.lm(al));
		host_u.shift(32'h0, dum, 1, 4'h0);
		host_u.recv(32 / dl, dl, got);
		host_u.end_frame();
	endtask
	task automatic cfg(input logic q, input logic p, input logic w);
		host_u.wait_clk(1);
		quad_en <= q;
		four_wire <= p;
		wrap_en <= w;
	endtask
	task automatic pulse_latch();
		host_u.wait_clk(1);
		latch_set <= 1'b1;
		host_u.wait_clk(1);
		latch_set <= 1'b0;
		host_u.wait_clk(2);
	endtask
	task automatic t_reads();
		logic [31:0] g;
		cfg(1'b1, 1'b0, 1'b0);
		rd(OP_QUAD_OUT, 1, 32'h0000_0210, 24, 1, 8, 4, g);
		chk(g, ex(24'h00_0210, 24'hff_ffff));
		rd(OP_DUAL_IO, 1, 32'h0003_20a0, 32, 2, 0, 2, g);
		chk(g, ex(24'h00_0320, 24'hff_ffff));
		rd(8'h00, 0, 32'h0004_40a5, 32, 2, 0, 2, g);
		chk(g, ex(24'h00_0440, 24'hff_ffff));
		rd(8'h00, 0, 32'h0005_5000, 32, 2, 0, 2, g);
		chk(g, ex(24'h00_0550, 24'hff_ffff));
		rd(OP_DUAL_IO, 1, 32'h0006_60a0, 32, 2, 0, 2, g);
		chk(g, ex(24'h00_0660, 24'hff_ffff));
		host_u.begin_frame();
		host_u.shift(32'hffff_ffff, 32, 2, 4'h3);
		host_u.end_frame();
		rd(OP_DUAL_IO, 1, 32'h0007_7000, 32, 2, 0, 2, g);
		chk(g, ex(24'h00_0770, 24'hff_ffff));
		host_u.wait_clk(1);
		wrap_len <= 2'h0;
		cfg(1'b1, 1'b0, 1'b1);
		rd(OP_QUAD_IO, 1, 32'h0001_06a0, 32, 4, 4, 4, g);
		chk(g, ex(24'h00_0106, 24'h00_0007));
		wrap_len <= 2'h2;
		rd(8'h00, 0, 32'h0001_3ea0, 32, 4, 4, 4, g);
		chk(g, ex(24'h00_013e, 24'h00_001f));
		cfg(1'b1, 1'b0, 1'b0);
		rd(8'h00, 0, 32'h0003_5000, 32, 4, 4, 4, g);
		chk(g, ex(24'h00_0350, 24'hff_ffff));
		cfg(1'b1, 1'b1, 1'b1);
		rd(OP_QUAD_IO, 4, 32'h0001_0600, 32, 4, 0, 4, g);
		chk(g, ex(24'h00_0106, 24'hff_ffff));
		rp6 <= 1'b1;
		rd(OP_QUAD_IO, 4, 32'h0002_0400, 32, 4, 2, 4, g);
		chk(g, ex(24'h00_0204, 24'hff_ffff));
		rp6 <= 1'b0;
		$display("test reads done");
	endtask
	task automatic t_refuse();
		logic [7:0]  ops[4] = '{OP_QUAD_OUT, OP_QUAD_IO, OP_DUAL_IO, OP_QUAD_OUT};
		logic [31:0] g;
		int          k;
		for (k = 0; k < 4; k++) begin
			cfg(k >= 2, k >= 2, 1'b0);
			oe_seen = 1'b0;
			rd(ops[k], (k >= 2) ? 4 : 1, 32'h0000_0100, 24, 1, 8, 4, g);
			chk(32'(oe_seen), 32'h0);
		end
		cfg(1'b0, 1'b0, 1'b0);
		$display("test refuse done");
	endtask
	task automatic t_program();
		logic [7:0] d[3] = '{8'ha5, 8'h5a, 8'hc3};
		int         k, n, j;
		pq.delete();
		pulse_latch();
		chk(32'(write_enable_latch), 32'h1);
		host_u.begin_frame();
		host_u.shift(32'(OP_PAGE_PGM), 8, 1, 4'h1);
		host_u.shift(32'h0012_fe, 24, 1, 4'h1);
		for (k = 0; k < 3; k++) host_u.shift(32'(d[k]), 8, 1, 4'h1);
		host_u.end_frame();
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			host_u.wait_clk(1);
			n++;
		end
		chk(32'(write_enable_latch), 32'h0);
		n = 0;
		while (busy === 1'b1 && n < 1000) begin
			host_u.wait_clk(1);
			n++;
		end
		host_u.wait_clk(2);
		chk(32'(busy_len), 32'(PGM_NS / CLK_PERIOD_NS));
		chk(32'(pq.size()), 32'h3);
		// Scan runs by byte address, so the wrapped byte comes out first
		for (k = 0; k < 3 && k < pq.size(); k++) begin
			j = (k + 2) % 3;
			chk(pq[k], {24'h00_1200 | 24'((8'hfe + j) & 8'hff), d[j]});
		end
		for (k = 0; k < 3; k++) begin
			pq.delete();
			if (k != 0) pulse_latch();
			page_protected <= (k == 2);
			host_u.begin_frame();
			host_u.shift(32'(OP_PAGE_PGM), 8, 1, 4'h1);
			host_u.shift(32'h0020_00, 24, 1, 4'h1);
			host_u.shift(32'h3c, 8, 1, 4'h1);
			if (k == 1) host_u.shift(32'h5, 3, 1, 4'h1);
			host_u.end_frame();
			host_u.wait_clk(600);
			chk(32'(pq.size()), 32'h0);
		end
		page_protected <= 1'b0;
		$display("test program done");
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{quad_en, four_wire, rp6, wrap_en, latch_set, page_protected} = 6'h00;
		wrap_len = 2'h0;
		oe_seen = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		host_u.wait_clk(5);
		t_reads();
		t_refuse();
		t_program();
		end_of_test();
	end
	// Tests need about 8500 cycles
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
endmodule
